// file: rmc_ctrl.sv
// Operating mode sequencer, event flags and serial register access.
// Assumes all pins are synchronous to ref_clk and the serial clock is slow.
`timescale 1ns/100ps

module rmc_ctrl #(
  parameter int POR_CYC    = rmc_pkg::POR_CYC,
  parameter int XTAL_CYC   = rmc_pkg::XTAL_CYC,
  parameter int CAL_CYC    = rmc_pkg::CAL_CYC,
  parameter int SETTLE_CYC = rmc_pkg::SETTLE_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               shutdown_pin,
  input  wire logic               spi_sclk,
  input  wire logic               spi_sel_n,
  input  wire logic               spi_sdi,
  output logic                    sdo_out,
  output logic                    sdo_oe,
  input  wire rmc_pkg::rmc_event_s events,
  input  wire rmc_pkg::rmc_flags_s flags,
  input  wire logic               pkt_done,
  output rmc_pkg::rmc_power_s     power,
  output logic [1:0]              chip_state,
  output logic                    irq_out_n
);

  rmc_pkg::rmc_core_s q;        // Registered state
  rmc_pkg::rmc_core_s d;        // Next state
  logic               rise;     // Serial clock rising edge
  logic               fall;     // Serial clock falling edge
  logic               spi_ok;   // Register space powered and out of reset
  logic               idle_lp;  // Idle with crystal off
  logic [7:0]         chip_stat; // Chip status byte

  // Counter reaches the last cycle of a step
  function automatic logic timer_hit(input logic [19:0] c, input int lim);
    timer_hit = (c == 20'(lim - 1));
  endfunction

  // Step that follows a running crystal
  function automatic rmc_pkg::rmc_state_e after_xtal(input logic [7:0] seqc);
    after_xtal = seqc[rmc_pkg::SEQ_VCOCAL] ? rmc_pkg::RMC_CAL : rmc_pkg::RMC_SETTLE;
  endfunction

  // Any enabled status bit pending
  function automatic logic pending(input rmc_pkg::rmc_core_s s);
    pending = |(s.stat1 & s.en1) | |(s.stat2 & s.en2);
  endfunction

  // Read mux; unmapped addresses read zero
  function automatic logic [7:0] read_reg(input rmc_pkg::rmc_core_s s, input logic [6:0] a,
                                          input logic [7:0] cs);
    unique case (a)
      rmc_pkg::ADDR_CHIP_STATUS: read_reg = cs;
      rmc_pkg::ADDR_EVT_STAT1:   read_reg = s.stat1;
      rmc_pkg::ADDR_EVT_STAT2:   read_reg = s.stat2;
      rmc_pkg::ADDR_EVT_EN1:     read_reg = s.en1;
      rmc_pkg::ADDR_EVT_EN2:     read_reg = s.en2;
      rmc_pkg::ADDR_MODE_CTRL:   read_reg = s.mode;
      rmc_pkg::ADDR_SEQ_CTRL:    read_reg = s.seqc;
      default:                   read_reg = 8'h00;
    endcase
  endfunction

  // Edge detection on the sampled serial clock
  assign rise = spi_sclk & ~q.sclk_q;
  assign fall = ~spi_sclk & q.sclk_q;
  // No register access while shut down or in power-on reset
  assign spi_ok = (q.st != rmc_pkg::RMC_OFF) && (q.st != rmc_pkg::RMC_POR);
  // Crystal off in idle; the low-power regulator only after the host saw the reset flags
  assign idle_lp = (q.st == rmc_pkg::RMC_IDLE) && !q.mode[rmc_pkg::MODE_XTON] &&
                   !q.mode[rmc_pkg::MODE_PLLON];

  // Chip power state code
  always_comb begin
    if (q.st == rmc_pkg::RMC_TX || q.st == rmc_pkg::RMC_RAMP) begin
      chip_state = rmc_pkg::CPS_TX;
    end else if (idle_lp || !spi_ok) begin
      chip_state = rmc_pkg::CPS_LOWPWR;
    end else begin
      chip_state = rmc_pkg::CPS_READY;
    end
  end

  // Chip status byte; reserved bits read zero
  assign chip_stat = {flags.ovfl, flags.unfl, 2'h0, flags.freqerr, 1'b0, chip_state};

  // Analog enables derived from the mode word and sequencer step
  always_comb begin
    power = '0;
    if (spi_ok) begin
      // Low-power supply only in standby and sleep
      power.low_power_regulator = idle_lp && q.por_read && !q.mode[rmc_pkg::MODE_ENLBD];
      power.main_reg_en = !power.low_power_regulator;
    end else begin
      power.main_reg_en = (q.st == rmc_pkg::RMC_POR);
    end
    // Crystal runs in ready, tune and every sequencer step
    power.xtal_en = (q.st >= rmc_pkg::RMC_XTAL) ||
                    ((q.st == rmc_pkg::RMC_IDLE) &&
                     (q.mode[rmc_pkg::MODE_XTON] | q.mode[rmc_pkg::MODE_PLLON]));
    power.synth_en = (q.st >= rmc_pkg::RMC_CAL) ||
                     ((q.st == rmc_pkg::RMC_IDLE) && q.mode[rmc_pkg::MODE_PLLON]);
    power.vco_cal = (q.st == rmc_pkg::RMC_CAL);
    power.pa_en = (q.st == rmc_pkg::RMC_RAMP) || (q.st == rmc_pkg::RMC_TX);
    power.tx_send = (q.st == rmc_pkg::RMC_TX);
    power.wut_en = spi_ok && (q.mode[rmc_pkg::MODE_ENWT] | q.mode[rmc_pkg::MODE_ENLBD]);
    power.lbd_en = spi_ok && q.mode[rmc_pkg::MODE_ENLBD];
  end

  // Next-state logic: sequencer, serial frame, flags
  always_comb begin
    logic [7:0] b;       // Completed serial byte
    logic [6:0] rd_addr; // Address whose data is loaded for shifting out
    logic       rd_go;   // Load read data this cycle
    logic       wr_go;   // Write data byte this cycle
    logic [7:0] s1set;   // Status one bits set this cycle
    logic [7:0] s2set;   // Status two bits set this cycle
    b = 8'h00;
    rd_addr = 7'h00;
    rd_go = 1'b0;
    wr_go = 1'b0;
    s1set = 8'h00;
    s2set = 8'h00;
    d = q;
    d.sclk_q = spi_sclk;
    d.cnt = q.cnt + 20'h00001;

    // Host clearing the transmit bit aborts any step back to idle
    if (q.st >= rmc_pkg::RMC_XTAL && !q.mode[rmc_pkg::MODE_TXON]) begin
      d.st = rmc_pkg::RMC_IDLE;
      d.cnt = '0;
    end else begin
      unique case (q.st)
        rmc_pkg::RMC_OFF: begin
          // Power-on reset begins once the pin has fallen
          d.st = rmc_pkg::RMC_POR;
          d.cnt = '0;
        end
        rmc_pkg::RMC_POR: begin
          if (timer_hit(q.cnt, POR_CYC)) begin
            d.st = rmc_pkg::RMC_IDLE;
            d.cnt = '0;
            s2set[rmc_pkg::ST2_POR] = 1'b1;
            s2set[rmc_pkg::ST2_CHIPRDY] = 1'b1;
          end
        end
        rmc_pkg::RMC_IDLE: begin
          d.cnt = '0;
          if (q.mode[rmc_pkg::MODE_TXON]) begin
            // Crystal already up in ready or tune, so its wait is skipped
            if (q.mode[rmc_pkg::MODE_XTON] | q.mode[rmc_pkg::MODE_PLLON]) begin
              d.st = after_xtal(q.seqc);
            end else begin
              d.st = rmc_pkg::RMC_XTAL;
            end
          end
        end
        rmc_pkg::RMC_XTAL: begin
          if (timer_hit(q.cnt, XTAL_CYC)) begin
            d.st = after_xtal(q.seqc);
            d.cnt = '0;
            s2set[rmc_pkg::ST2_CHIPRDY] = 1'b1;
          end
        end
        rmc_pkg::RMC_CAL: begin
          if (timer_hit(q.cnt, CAL_CYC)) begin
            d.st = rmc_pkg::RMC_SETTLE;
            d.cnt = '0;
          end
        end
        rmc_pkg::RMC_SETTLE: begin
          if (timer_hit(q.cnt, SETTLE_CYC)) begin
            d.st = rmc_pkg::RMC_RAMP;
            d.cnt = '0;
          end
        end
        rmc_pkg::RMC_RAMP: begin
          // Ramp is short, so it stays a fixed constant
          if (timer_hit(q.cnt, rmc_pkg::RAMP_CYC)) begin
            d.st = rmc_pkg::RMC_TX;
            d.cnt = '0;
          end
        end
        rmc_pkg::RMC_TX: begin
          d.cnt = '0;
          // Packet done returns to the idle mode that was selected
          if (pkt_done) begin
            d.st = rmc_pkg::RMC_IDLE;
            d.mode[rmc_pkg::MODE_TXON] = 1'b0;
            s1set[rmc_pkg::ST1_PKSENT] = 1'b1;
          end
        end
      endcase
    end

    // Serial frame: write bit, 7-bit address, then data bytes with auto-increment
    if (spi_sel_n || !spi_ok) begin
      d.bitc = '0;
      d.phase = 1'b0;
      d.sdo = 1'b1;
    end else begin
      if (rise) begin
        b = {q.sh_in[6:0], spi_sdi};
        d.sh_in = b;
        d.bitc = q.bitc + 3'h1;
        if (q.bitc == 3'h7) begin
          if (!q.phase) begin
            // Address byte
            d.phase = 1'b1;
            d.rw = b[7];
            d.addr = b[6:0];
            rd_addr = b[6:0];
            rd_go = !b[7];
          end else begin
            // Data byte, then step to the next register for a burst
            wr_go = q.rw;
            d.addr = q.addr + 7'h01;
            rd_addr = q.addr + 7'h01;
            rd_go = !q.rw;
          end
        end
      end
      // Read data leaves on falling edges, MSB first
      if (fall && q.phase && !q.rw) begin
        d.sdo = q.sh_out[7];
        d.sh_out = {q.sh_out[6:0], 1'b0};
      end
    end

    // A status read clears only its enabled bits
    if (rd_go) begin
      d.sh_out = read_reg(q, rd_addr, chip_stat);
      if (rd_addr == rmc_pkg::ADDR_EVT_STAT1) begin
        d.stat1 = q.stat1 & ~q.en1;
      end
      if (rd_addr == rmc_pkg::ADDR_EVT_STAT2) begin
        d.stat2 = q.stat2 & ~q.en2;
        d.por_read = 1'b1;
      end
    end

    // Register writes; read-only addresses ignore writes
    if (wr_go) begin
      unique case (q.addr)
        rmc_pkg::ADDR_EVT_EN1:  d.en1 = b;
        rmc_pkg::ADDR_EVT_EN2:  d.en2 = b;
        rmc_pkg::ADDR_SEQ_CTRL: d.seqc = b;
        rmc_pkg::ADDR_MODE_CTRL: begin
          if (b[rmc_pkg::MODE_SOFTWARE_RESET]) begin
            // Software reset restores defaults and lands in ready
            d.en1 = rmc_pkg::EN1_RST;
            d.en2 = rmc_pkg::EN2_RST;
            d.mode = rmc_pkg::MODE_RST;
            d.seqc = rmc_pkg::SEQ_RST;
            d.stat1 = 8'h00;
            d.stat2 = 8'h00;
            d.st = rmc_pkg::RMC_IDLE;
            d.cnt = '0;
          end else begin
            d.mode = b;
          end
        end
        default: ;
      endcase
    end

    // Events set their flags whether enabled or not; a set beats a same-cycle clear
    s1set[rmc_pkg::ST1_FFERR] = events.fifo_err;
    s1set[rmc_pkg::ST1_AFULL] = events.tx_afull;
    s1set[rmc_pkg::ST1_AEMPTY] = events.tx_aempty;
    s1set[rmc_pkg::ST1_EXT] = events.ext;
    s2set[rmc_pkg::ST2_WUT] = events.wut;
    s2set[rmc_pkg::ST2_LBD] = events.lbd;
    if (spi_ok || s2set[rmc_pkg::ST2_POR]) begin
      d.stat1 = d.stat1 | s1set;
      d.stat2 = d.stat2 | s2set;
    end
    // Interrupt follows enabled pending bits, released once they are read
    d.irq_n = !pending(d);

    // Shutdown pin overrides everything and wipes the registers
    if (shutdown_pin) begin
      d = rmc_pkg::CORE_RST;
      d.st = rmc_pkg::RMC_OFF;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= rmc_pkg::CORE_RST;
    end else begin
      q <= d;
    end
  end

  // Serial data and interrupt pins from flip-flops; output enable straight from select and state
  assign sdo_out = q.sdo;
  assign sdo_oe = !spi_sel_n && spi_ok;
  assign irq_out_n = q.irq_n;

  // Sequencer start from a crystal-off idle mode
  sequence s_tx_cold;
    q.st == rmc_pkg::RMC_IDLE && q.mode[rmc_pkg::MODE_TXON] &&
    !q.mode[rmc_pkg::MODE_XTON] && !q.mode[rmc_pkg::MODE_PLLON] && !shutdown_pin;
  endsequence
  // Crystal step finishing with calibration disabled
  sequence s_xtal_nocal;
    q.st == rmc_pkg::RMC_XTAL && timer_hit(q.cnt, XTAL_CYC) &&
    !q.seqc[rmc_pkg::SEQ_VCOCAL] && q.mode[rmc_pkg::MODE_TXON] && !shutdown_pin;
  endsequence

  shutdown_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    shutdown_pin |=> q.st == rmc_pkg::RMC_OFF && !sdo_oe)
    else $error("shutdown pin did not force shutdown");
  por_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.st == rmc_pkg::RMC_POR && timer_hit(q.cnt, POR_CYC) && !shutdown_pin
    |=> q.st == rmc_pkg::RMC_IDLE && q.mode == rmc_pkg::MODE_RST && q.stat2[rmc_pkg::ST2_POR])
    else $error("reset did not end in ready mode");
  spi_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.st == rmc_pkg::RMC_OFF |-> !sdo_oe && q.en2 == rmc_pkg::EN2_RST)
    else $error("register access while shut down");
  cold_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_tx_cold |=> q.st == rmc_pkg::RMC_XTAL ##1 q.st == rmc_pkg::RMC_XTAL || shutdown_pin || !rst_n
      || !q.mode[rmc_pkg::MODE_TXON])
    else $error("cold transmit start skipped the crystal wait");
  cal_skip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_xtal_nocal |=> q.st == rmc_pkg::RMC_SETTLE && q.cnt == 20'h00000)
    else $error("calibration not skipped");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pending(q) && !$past(shutdown_pin) |-> !irq_out_n)
    else $error("enabled pending event left interrupt high");
  read_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise && !spi_sel_n && spi_ok && !q.phase && q.bitc == 3'h7 && q.st == rmc_pkg::RMC_IDLE
    && {q.sh_in[6:0], spi_sdi} == {1'b0, rmc_pkg::ADDR_EVT_STAT2} && !shutdown_pin
    |=> (q.stat2 & $past(q.en2) & ~$past({4'h0, events.wut, events.lbd, 2'h0})) == 8'h00)
    else $error("status read left enabled bits set");
  lp_reg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    power.low_power_regulator |-> q.st == rmc_pkg::RMC_IDLE && !power.xtal_en && !power.main_reg_en
      && q.por_read)
    else $error("low-power regulator outside standby or sleep");
  tune_xtal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.st == rmc_pkg::RMC_IDLE && q.mode[rmc_pkg::MODE_PLLON] |-> power.xtal_en && power.synth_en)
    else $error("tune mode without crystal");

endmodule

// file: rmc_pkg.sv
// Shared constants and types for the radio mode control block.
// Assumes a 50 MHz reference clock and a host on a 16-bit serial frame.
package rmc_pkg;

  // Register addresses on the serial frame
  localparam logic [6:0] ADDR_CHIP_STATUS = 7'h02;
  localparam logic [6:0] ADDR_EVT_STAT1   = 7'h03;
  localparam logic [6:0] ADDR_EVT_STAT2   = 7'h04;
  localparam logic [6:0] ADDR_EVT_EN1     = 7'h05;
  localparam logic [6:0] ADDR_EVT_EN2     = 7'h06;
  localparam logic [6:0] ADDR_MODE_CTRL   = 7'h07;
  localparam logic [6:0] ADDR_SEQ_CTRL    = 7'h08;

  // Mode and sequencer control bit positions
  localparam int MODE_XTON    = 0;
  localparam int MODE_PLLON   = 1;
  localparam int MODE_TXON    = 3;
  localparam int MODE_ENLBD   = 5;
  localparam int MODE_ENWT    = 6;
  localparam int MODE_SOFTWARE_RESET = 7;
  localparam int SEQ_VCOCAL   = 0;

  // Event status bit positions
  localparam int ST1_FFERR  = 7;
  localparam int ST1_AFULL  = 6;
  localparam int ST1_AEMPTY = 5;
  localparam int ST1_EXT    = 3;
  localparam int ST1_PKSENT = 2;
  localparam int ST2_WUT    = 3;
  localparam int ST2_LBD    = 2;
  localparam int ST2_CHIPRDY = 1;
  localparam int ST2_POR    = 0;

  // Reset values
  localparam logic [7:0] EN1_RST  = 8'h00;
  localparam logic [7:0] EN2_RST  = 8'h01;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] SEQ_RST  = 8'h01;

  // Chip power state codes
  localparam logic [1:0] CPS_LOWPWR = 2'h0;
  localparam logic [1:0] CPS_READY  = 2'h1;
  localparam logic [1:0] CPS_TX     = 2'h2;

  // Sequencer step times in ns, and their cycle counts (least times round up)
  localparam int CLK_PERIOD_NS  = 20;
  localparam int POR_TIME_NS    = 16600000;
  localparam int XTAL_TIME_NS   = 600000;
  localparam int CAL_TIME_NS    = 100000;
  localparam int SETTLE_TIME_NS = 90000;
  localparam int RAMP_TIME_NS   = 10000;
  localparam int POR_CYC    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XTAL_CYC   = (XTAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CYC    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_CYC   = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RMC_OFF, RMC_POR, RMC_IDLE, RMC_XTAL, RMC_CAL, RMC_SETTLE, RMC_RAMP, RMC_TX
  } rmc_state_e;

  // One-cycle event pulses from the radio
  typedef struct packed {
    logic fifo_err; logic tx_afull; logic tx_aempty; logic ext; logic wut; logic lbd;
  } rmc_event_s;

  // Level flags shown in chip status
  typedef struct packed {
    logic ovfl; logic unfl; logic freqerr;
  } rmc_flags_s;

  // Block enables driven to the analog side
  typedef struct packed {
    logic main_reg_en; logic low_power_regulator; logic xtal_en; logic synth_en;
    logic vco_cal; logic pa_en; logic tx_send; logic wut_en; logic lbd_en;
  } rmc_power_s;

  // Whole state of the control module
  typedef struct packed {
    rmc_state_e st; logic [19:0] cnt; logic sclk_q; logic [7:0] sh_in;
    logic [2:0] bitc; logic phase; logic rw; logic [6:0] addr; logic [7:0] sh_out;
    logic sdo; logic [7:0] en1; logic [7:0] en2; logic [7:0] stat1; logic [7:0] stat2;
    logic [7:0] mode; logic [7:0] seqc; logic por_read; logic irq_n;
  } rmc_core_s;

  localparam rmc_core_s CORE_RST = '{st: RMC_POR, sdo: 1'b1, irq_n: 1'b1, en1: EN1_RST,
                                     en2: EN2_RST, mode: MODE_RST, seqc: SEQ_RST, default: '0};

endpackage

// file: rmc_host_model.sv
// Host side model: a serial master that frames register accesses.
// Assumes the device samples the serial lines with ref_clk.
`timescale 1ns/100ps
module rmc_host_model #(
  parameter int HALF = 4  // Cycles per serial clock phase, above the two needed
) (
  input  wire logic ref_clk,
  output logic      spi_sclk,
  output logic      spi_sel_n,
  output logic      spi_sdi,
  input  wire logic sdo_out
);
  logic [15:0] frame;  // Outgoing word, write bit first

  // Idle bus: select high, clock parked low between frames
  initial begin
    spi_sclk  = 1'b0;
    spi_sel_n = 1'b1;
    spi_sdi   = 1'b1;
  end

  // One frame, MSB first; read data is taken just before each rise
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    frame = {wr, addr, wr ? wdata : 8'h5A};
    @(posedge ref_clk) spi_sel_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi  <= frame[i];
      spi_sclk <= 1'b0;
      repeat (HALF) @(posedge ref_clk);
      // Data phase: sample what the device shifted out after the fall
      if (i < 8) begin
        rdata[i] = sdo_out;
      end
      spi_sclk <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
    end
    spi_sclk <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    spi_sel_n <= 1'b1;
    // Released line flips so no stale bit can pass for data
    spi_sdi <= ~spi_sdi;
    repeat (HALF) @(posedge ref_clk);
  endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the radio mode control block.
// Assumes the host model frames every register access.
`timescale 1ns/100ps
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module tb_top;
  // Short counts keep the run brief; expectations follow them
  localparam int POR  = 20;
  localparam int XTAL = 200;
  localparam int CAL  = 5;
  localparam int SETL = 5;
  // Host write task returns this many cycles after its write lands
  localparam int TAIL = 11;
  typedef struct packed {
    logic wr; logic [6:0] addr; logic [7:0] data; logic [8:0] exp;
  } rmc_row_s;
  // Reads compare data; mode writes compare enables less the cal bit
  localparam rmc_row_s ROWS [15] = '{
    '{1'b0, 7'h05, 8'h00, 9'h000},
    '{1'b0, 7'h06, 8'h00, 9'h001},
    '{1'b0, 7'h07, 8'h00, 9'h001},
    '{1'b0, 7'h04, 8'h00, 9'h003},
    '{1'b0, 7'h04, 8'h00, 9'h002},
    '{1'b1, 7'h05, 8'hEC, 9'h000},
    '{1'b0, 7'h05, 8'h00, 9'h0EC},
    '{1'b0, 7'h10, 8'h00, 9'h000},
    '{1'b1, 7'h02, 8'hFF, 9'h000},
    '{1'b0, 7'h02, 8'h00, 9'h001},
    '{1'b1, 7'h07, 8'h00, 9'h080},
    '{1'b1, 7'h07, 8'h40, 9'h082},
    '{1'b1, 7'h07, 8'h20, 9'h103},
    '{1'b1, 7'h07, 8'h01, 9'h140},
    '{1'b1, 7'h07, 8'h02, 9'h160}
  };
  logic                ref_clk;       // Reference clock
  logic                rst_n;         // Reset, active low
  logic                shutdown_pin;  // Shutdown request
  logic                spi_sclk;      // Serial clock from host
  logic                spi_sel_n;     // Serial select
  logic                spi_sdi;       // Serial data in
  logic                sdo_out;       // Serial data out
  logic                sdo_oe;        // Serial out enable
  rmc_pkg::rmc_event_s events;        // Event pulses
  rmc_pkg::rmc_flags_s flags;         // Status levels
  logic                pkt_done;      // Packet end
  rmc_pkg::rmc_power_s power;         // Block enables
  logic [1:0]          chip_state;    // Power state
  logic                irq_out_n;     // Interrupt, active low
  logic [7:0]          rd;            // Last read byte
  int                  checked;       // Comparisons made
  int                  miscompares;   // Mismatches seen
  int                  n;             // Cycle count
  int                  t_rdy;         // Cycles to send from ready
  int                  t_nocal;       // Same, calibration skipped
  int                  t_stby;        // Cycles to send from standby

  rmc_ctrl #(.POR_CYC(POR), .XTAL_CYC(XTAL), .CAL_CYC(CAL), .SETTLE_CYC(SETL)) rmc_ctrl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .shutdown_pin(shutdown_pin), .spi_sclk(spi_sclk),
    .spi_sel_n(spi_sel_n), .spi_sdi(spi_sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .events(events), .flags(flags), .pkt_done(pkt_done), .power(power),
    .chip_state(chip_state), .irq_out_n(irq_out_n));
  rmc_host_model rmc_host_model_inst (
    .ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_sel_n(spi_sel_n), .spi_sdi(spi_sdi),
    .sdo_out(sdo_out));

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // Single verdict point for the run and for the watchdog
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bounded wait for the device to settle in ready
  task automatic wait_ready(output int cnt);
    cnt = 0;
    // Sampled on the falling edge, where the state has settled
    while (chip_state !== rmc_pkg::CPS_READY && cnt < 200) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask

  // Short register access helpers
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    rmc_host_model_inst.xfer(1'b0, a, 8'h00, rd);
    `CHK(rd, e)
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    rmc_host_model_inst.xfer(1'b1, a, d, rd);
  endtask

  // Start a send from mode m, time it, end it, check txon dropped
  task automatic run_tx(input logic [7:0] m, output int cnt);
    wr(rmc_pkg::ADDR_MODE_CTRL, m | 8'h08);
    cnt = 0;
    while (power.tx_send !== 1'b1 && cnt < 2000) begin
      @(negedge ref_clk);
      cnt++;
    end
    `CHK(chip_state, rmc_pkg::CPS_TX)
    @(posedge ref_clk) pkt_done <= 1'b1;
    @(posedge ref_clk) pkt_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_chk(rmc_pkg::ADDR_MODE_CTRL, m);
  endtask

  // Hang guard, well beyond the expected run of some 7800 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    end_of_test();
  end

  // Main sequence: table first, then awkward cases
  initial begin
    ref_clk = 1'b0; rst_n = 1'b0; shutdown_pin = 1'b0; events = '0; flags = '0; pkt_done = 1'b0;
    checked = 0; miscompares = 0;
    repeat (20) @(posedge ref_clk);
    `CHK({irq_out_n, sdo_oe}, 2'b10)
    rst_n <= 1'b1;
    wait_ready(n);
    `CHK(n inside {[POR - 2:POR + 3]}, 1'b1)
    `CHK(irq_out_n, 1'b0)
    $display("test reset done");
    for (int i = 0; i < 15; i++) begin
      rmc_host_model_inst.xfer(ROWS[i].wr, ROWS[i].addr, ROWS[i].data, rd);
      if (!ROWS[i].wr)
        `CHK(rd, ROWS[i].exp[7:0])
      else if (ROWS[i].addr == rmc_pkg::ADDR_MODE_CTRL)
        `CHK(power & 9'h1EF, ROWS[i].exp)
    end
    `CHK(irq_out_n, 1'b1)
    $display("test table done");
    // Enabled event pulls the line; the status read frees it
    @(posedge ref_clk) events <= '{ext: 1'b1, default: 1'b0};
    @(posedge ref_clk) events <= '{lbd: 1'b1, default: 1'b0};
    @(posedge ref_clk) events <= '0;
    `CHK(irq_out_n, 1'b0)
    rd_chk(rmc_pkg::ADDR_EVT_STAT1, 8'h08);
    `CHK(irq_out_n, 1'b1)
    rd_chk(rmc_pkg::ADDR_EVT_STAT2, 8'h06);
    rd_chk(rmc_pkg::ADDR_EVT_STAT2, 8'h06);
    flags <= '{ovfl: 1'b1, unfl: 1'b0, freqerr: 1'b1};
    rd_chk(rmc_pkg::ADDR_CHIP_STATUS, 8'h89);
    flags <= '0;
    $display("test events done");
    // Send timing from ready, without calibration, and from standby
    run_tx(8'h01, t_rdy);
    `CHK(irq_out_n, 1'b0)
    rd_chk(rmc_pkg::ADDR_EVT_STAT1, 8'h04);
    `CHK(t_rdy inside {[CAL + SETL + rmc_pkg::RAMP_CYC - TAIL:CAL + SETL + rmc_pkg::RAMP_CYC - TAIL + 4]}, 1'b1)
    wr(rmc_pkg::ADDR_SEQ_CTRL, 8'h00);
    run_tx(8'h01, t_nocal);
    `CHK(t_rdy - t_nocal, CAL)
    wr(rmc_pkg::ADDR_SEQ_CTRL, 8'h01);
    run_tx(8'h00, t_stby);
    `CHK((t_stby - t_rdy) inside {[XTAL:XTAL + 2]}, 1'b1)
    // Cold start with calibration disabled goes straight to settling
    wr(rmc_pkg::ADDR_SEQ_CTRL, 8'h00);
    run_tx(8'h00, n);
    `CHK(t_stby - n, CAL)
    $display("test sequencer done");
    // Software reset restores defaults and lands in ready
    wr(rmc_pkg::ADDR_EVT_EN1, 8'hEC);
    wr(rmc_pkg::ADDR_MODE_CTRL, 8'h80);
    rd_chk(rmc_pkg::ADDR_MODE_CTRL, 8'h01);
    rd_chk(rmc_pkg::ADDR_EVT_EN1, 8'h00);
    rd_chk(rmc_pkg::ADDR_SEQ_CTRL, 8'h01);
    $display("test soft reset done");
    // Shutdown loses all state and reruns the power-on wait
    wr(rmc_pkg::ADDR_EVT_EN1, 8'hEC);
    @(posedge ref_clk) shutdown_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK(chip_state, rmc_pkg::CPS_LOWPWR)
    `CHK({power, sdo_oe}, 10'h000)
    @(posedge ref_clk) shutdown_pin <= 1'b0;
    wait_ready(n);
    `CHK(n inside {[POR - 2:POR + 3]}, 1'b1)
    rd_chk(rmc_pkg::ADDR_EVT_EN1, 8'h00);
    rd_chk(rmc_pkg::ADDR_EVT_STAT2, 8'h03);
    $display("test shutdown done");
    end_of_test();
  end
endmodule
